// >>> rtl/pse_event_pkg.sv
package pse_event_pkg;
    // ----------------------------------------
    // command codes
    // ----------------------------------------
    localparam logic [7:0] CMD_POWER_EVENT     = 8'h02;
    localparam logic [7:0] CMD_POWER_EVENT_CLR = 8'h03;
    localparam logic [7:0] CMD_DISC_EVENT      = 8'h04;
    localparam logic [7:0] CMD_DISC_EVENT_CLR  = 8'h05;
    localparam logic [7:0] CMD_FAULT_EVENT     = 8'h06;
    localparam logic [7:0] CMD_FAULT_EVENT_CLR = 8'h07;
    localparam logic [7:0] CMD_START_EVENT     = 8'h08;
    localparam logic [7:0] CMD_START_EVENT_CLR = 8'h09;
    localparam logic [7:0] CMD_SUPPLY_EVENT    = 8'h0a;
    localparam logic [7:0] CMD_SUPPLY_EVENT_CLR= 8'h0b;

    // ----------------------------------------
    // layout and reset values
    // ----------------------------------------
    localparam int         NUM_CHANNELS        = 4;
    localparam int         HI_FIELD_LSB        = 4;
    localparam int         LO_FIELD_LSB        = 0;
    localparam logic [7:0] EVENT_RESET         = 8'h00;
    localparam logic [7:0] SUPPLY_RESET        = 8'h70;
    localparam logic [7:0] SUPPLY_USED_MASK    = 8'hf3;
    localparam logic [7:0] READ_ZERO           = 8'h00;

    // summary bit positions in the interrupt flags
    localparam int         SUM_SUPPLY          = 7;
    localparam int         SUM_START           = 6;
    localparam int         SUM_LIMIT           = 5;
    localparam int         SUM_CLASS           = 4;
    localparam int         SUM_DETECT          = 3;
    localparam int         SUM_UNPLUG          = 2;
    localparam int         SUM_PGOOD           = 1;
    localparam int         SUM_PENABLE         = 0;

    typedef enum logic [2:0] {
        SEL_NONE    = 3'b000,
        SEL_POWER   = 3'b001,
        SEL_DISC    = 3'b010,
        SEL_FAULT   = 3'b011,
        SEL_START   = 3'b100,
        SEL_SUPPLY  = 3'b101
    } reg_sel_t;
endpackage

// >>> rtl/event_reg_if.sv
`timescale 1ns/1ps
interface event_reg_if;
    logic [7:0] set_bits;
    logic [7:0] clr_bits;
    logic [7:0] value;
    modport owner (output set_bits, output clr_bits, input  value);
    modport latch (input  set_bits, input  clr_bits, output value);
endinterface

// >>> rtl/event_latch.sv
`timescale 1ns/1ps
module event_latch
    import pse_event_pkg::*;
#(
    parameter logic [7:0] RESET_VALUE = EVENT_RESET
) (
    input  wire logic mclk_i,
    input  wire logic nrst_i,
    event_reg_if.latch port
);
    // ----------------------------------------
    // sticky bits, set has priority over clear
    // ----------------------------------------
    logic [7:0] value;
    logic [7:0] next_value;

    assign next_value = (value & ~port.clr_bits) | port.set_bits; // RULE21
    assign port.value = value;

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            value <= RESET_VALUE;
        end else begin
            value <= next_value;
        end
    end
endmodule

// >>> rtl/pse_event_status_registers.sv
//Function
// RULE1 - fault events: 06h plain read, 07h clears
// RULE2 - start/limit events: 08h plain, 09h clears
// RULE3 - supply events: 0Ah plain, 0Bh clears
// RULE4 - clearing read releases interrupt if sole source
// RULE5 - channel off clears fault, start bits
// RULE6 - class bits: any cycle or change only
// RULE7 - detect bits: any cycle or change only
// RULE8 - fault: unplug high, overload trip low
// RULE9 - clearing overload flag leaves timers untouched
// RULE10 - clamp flags set after limit time exceeded
// RULE11 - turn-on fail flags on start/discovery errors
// RULE12 - start fail plus power change means inrush
// RULE13 - start fail alone records power-on cause
// RULE14 - auto mode ignores invalid discovery results
// RULE15 - supply register bit layout, bits 3-2 reserved
// RULE16 - active high, bit n-1 is channel n
// RULE17 - any set bit feeds summary flag
// RULE18 - output needs mask bit and global enable
// RULE19 - power event: good change high, enable low
// RULE20 - alert low while enabled flag set
// RULE21 - event during clearing read stays latched
`timescale 1ns/1ps
module pse_event_status_registers
    import pse_event_pkg::*;
#(
    parameter int CHANNELS = NUM_CHANNELS
) (
    input  wire logic       mclk_i,
    input  wire logic       nrst_i,
    input  wire logic       cmd_valid_i,
    input  wire logic [7:0] cmd_code_i,
    output logic      [7:0] rd_data_o,
    output logic            rd_valid_o,
    output logic            rd_unmapped_o,
    input  wire logic [3:0] pgood_change_i,
    input  wire logic [3:0] penable_change_i,
    input  wire logic [3:0] class_done_i,
    input  wire logic [3:0] class_differs_i,
    input  wire logic [3:0] detect_done_i,
    input  wire logic [3:0] detect_differs_i,
    input  wire logic       class_change_only_sel,
    input  wire logic       detect_change_only_sel,
    input  wire logic [3:0] unplug_i,
    input  wire logic [3:0] overload_trip_i,
    input  wire logic [3:0] current_clamp_i,
    input  wire logic [3:0] start_timer_fault_i,
    input  wire logic [3:0] discovery_error_i,
    input  wire logic [7:0] start_cause_i,
    input  wire logic       auto_mode_i,
    input  wire logic [3:0] channel_off_i,
    input  wire logic [7:0] supply_event_i,
    input  wire logic [7:0] alert_mask_i,
    input  wire logic       alert_global_enable,
    output logic      [7:0] alert_flags_o,
    output logic            alert_n_o,
    output logic      [3:0] inrush_fault_o,
    output logic      [7:0] power_on_fault_o,
    output logic            power_on_fault_upd_o
);
    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    if (CHANNELS != NUM_CHANNELS) begin : g_bad_channels
        $error("only a group of four channels is supported");
    end
    if (HI_FIELD_LSB != LO_FIELD_LSB + NUM_CHANNELS) begin : g_bad_layout
        $error("channel fields must share one byte side by side");
    end
    // reserved supply bits must come out of reset clear; reads mask them anyway
    if ((SUPPLY_RESET & ~SUPPLY_USED_MASK) != READ_ZERO) begin : g_bad_supply_reset
        $error("supply reset value sets a reserved bit");
    end

    // ----------------------------------------
    // local constants
    // ----------------------------------------
    localparam int         CAUSE_BITS = 2;
    localparam logic [3:0] FIELD_ALL  = 4'hf;
    localparam logic [3:0] FIELD_NONE = 4'h0;
    localparam logic [7:0] REG_ALL    = 8'hff;

    if (NUM_CHANNELS * CAUSE_BITS != $bits(power_on_fault_o)) begin : g_bad_cause
        $error("cause store must hold one field per channel");
    end

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    function automatic reg_sel_t decode_sel(input logic [7:0] code);
        case (code)
            CMD_POWER_EVENT, CMD_POWER_EVENT_CLR:   decode_sel = SEL_POWER;
            CMD_DISC_EVENT, CMD_DISC_EVENT_CLR:     decode_sel = SEL_DISC;
            CMD_FAULT_EVENT, CMD_FAULT_EVENT_CLR:   decode_sel = SEL_FAULT;
            CMD_START_EVENT, CMD_START_EVENT_CLR:   decode_sel = SEL_START;
            CMD_SUPPLY_EVENT, CMD_SUPPLY_EVENT_CLR: decode_sel = SEL_SUPPLY;
            default:                                decode_sel = SEL_NONE;
        endcase
    endfunction

    // odd code of each pair is the clearing read
    function automatic logic [7:0] clear_all(input logic hit);
        clear_all = hit ? REG_ALL : READ_ZERO;
    endfunction

    reg_sel_t   sel;
    logic       is_clear_cmd;
    logic       clr_power;
    logic       clr_disc;
    logic       clr_fault;
    logic       clr_start;
    logic       clr_supply;

    assign sel          = cmd_valid_i ? decode_sel(cmd_code_i) : SEL_NONE;
    assign is_clear_cmd = cmd_code_i[0];
    assign clr_power    = (sel == SEL_POWER)  && is_clear_cmd;
    assign clr_disc     = (sel == SEL_DISC)   && is_clear_cmd;
    assign clr_fault    = (sel == SEL_FAULT)  && is_clear_cmd;   // RULE1
    assign clr_start    = (sel == SEL_START)  && is_clear_cmd;   // RULE2
    assign clr_supply   = (sel == SEL_SUPPLY) && is_clear_cmd;   // RULE3

    // ----------------------------------------
    // register instances
    // ----------------------------------------
    event_reg_if power_if ();
    event_reg_if disc_if ();
    event_reg_if fault_if ();
    event_reg_if start_if ();
    event_reg_if supply_if ();

    event_latch #(.RESET_VALUE(EVENT_RESET)) u_power (
        .mclk_i (mclk_i),
        .nrst_i (nrst_i),
        .port   (power_if.latch)
    );
    event_latch #(.RESET_VALUE(EVENT_RESET)) u_disc (
        .mclk_i (mclk_i),
        .nrst_i (nrst_i),
        .port   (disc_if.latch)
    );
    event_latch #(.RESET_VALUE(EVENT_RESET)) u_fault (
        .mclk_i (mclk_i),
        .nrst_i (nrst_i),
        .port   (fault_if.latch)
    );
    event_latch #(.RESET_VALUE(EVENT_RESET)) u_start (
        .mclk_i (mclk_i),
        .nrst_i (nrst_i),
        .port   (start_if.latch)
    );
    event_latch #(.RESET_VALUE(SUPPLY_RESET)) u_supply (
        .mclk_i (mclk_i),
        .nrst_i (nrst_i),
        .port   (supply_if.latch)
    );

    // ----------------------------------------
    // per-channel fields
    // ----------------------------------------
    logic [3:0] power_hi;
    logic [3:0] power_lo;
    logic [3:0] disc_hi;
    logic [3:0] disc_lo;
    logic [3:0] fault_hi;
    logic [3:0] fault_lo;
    logic [3:0] start_hi;
    logic [3:0] start_lo;

    assign power_hi = power_if.value[HI_FIELD_LSB +: NUM_CHANNELS];
    assign power_lo = power_if.value[LO_FIELD_LSB +: NUM_CHANNELS];
    assign disc_hi  = disc_if.value[HI_FIELD_LSB +: NUM_CHANNELS];
    assign disc_lo  = disc_if.value[LO_FIELD_LSB +: NUM_CHANNELS];
    assign fault_hi = fault_if.value[HI_FIELD_LSB +: NUM_CHANNELS];
    assign fault_lo = fault_if.value[LO_FIELD_LSB +: NUM_CHANNELS];
    assign start_hi = start_if.value[HI_FIELD_LSB +: NUM_CHANNELS];
    assign start_lo = start_if.value[LO_FIELD_LSB +: NUM_CHANNELS];

    // ----------------------------------------
    // set sources
    // ----------------------------------------
    logic [3:0] class_set;
    logic [3:0] detect_set;
    logic [3:0] discovery_fail;
    logic [3:0] turn_on_fail;
    logic [3:0] off_kept;
    logic [3:0] inrush_now;
    logic [3:0] cause_upd;

    // change-only mode needs a differing result, else any finished cycle sets
    assign class_set      = class_done_i  & (class_change_only_sel  ? class_differs_i  : FIELD_ALL); // RULE6
    assign detect_set     = detect_done_i & (detect_change_only_sel ? detect_differs_i : FIELD_ALL); // RULE7
    assign discovery_fail = auto_mode_i ? FIELD_NONE : discovery_error_i;                    // RULE14
    assign turn_on_fail   = start_timer_fault_i | discovery_fail;                            // RULE11
    // channel off wins over new events: no fault or start bit should stay flagged on a dead channel
    assign off_kept       = ~channel_off_i;

    assign power_if.set_bits  = {pgood_change_i, penable_change_i};                          // RULE19
    assign power_if.clr_bits  = clear_all(clr_power);
    assign disc_if.set_bits   = {class_set, detect_set};                                     // RULE16
    assign disc_if.clr_bits   = clear_all(clr_disc);
    assign fault_if.set_bits  = {unplug_i & off_kept, overload_trip_i & off_kept};           // RULE8
    // only the flag is cleared; the clamp and overload timers live elsewhere
    assign fault_if.clr_bits  = clear_all(clr_fault) | {channel_off_i, channel_off_i};       // RULE5 RULE9
    assign start_if.set_bits  = {current_clamp_i & off_kept, turn_on_fail & off_kept};       // RULE10 RULE11
    assign start_if.clr_bits  = clear_all(clr_start) | {channel_off_i, channel_off_i};       // RULE5
    assign supply_if.set_bits = supply_event_i & SUPPLY_USED_MASK;                           // RULE15
    assign supply_if.clr_bits = clear_all(clr_supply);

    // ----------------------------------------
    // start fault diagnosis
    // ----------------------------------------
    logic [3:0] pe_flags;
    logic [7:0] next_cause;

    assign pe_flags   = power_lo | penable_change_i;
    assign inrush_now = turn_on_fail & pe_flags;                                             // RULE12
    assign cause_upd  = turn_on_fail & ~pe_flags;                                            // RULE13

    always_comb begin
        next_cause = power_on_fault_o;
        for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
            if (cause_upd[ch]) begin
                next_cause[CAUSE_BITS*ch +: CAUSE_BITS] = start_cause_i[CAUSE_BITS*ch +: CAUSE_BITS]; // RULE13
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            inrush_fault_o       <= FIELD_NONE;
            power_on_fault_o     <= READ_ZERO;
            power_on_fault_upd_o <= 1'b0;
        end else begin
            // channel off wins here too, as for the start bits
            inrush_fault_o       <= (inrush_fault_o | inrush_now) & off_kept;
            power_on_fault_o     <= next_cause;
            power_on_fault_upd_o <= |cause_upd;
        end
    end

    // ----------------------------------------
    // interrupt summary and alert pin
    // ----------------------------------------
    logic [7:0] next_flags;
    logic       alert_req;
    logic       next_alert_n;

    assign next_flags[SUM_SUPPLY]  = |supply_if.value;                                       // RULE17
    assign next_flags[SUM_START]   = |start_lo;
    // overload and clamp faults share one summary bit, as they share one mask bit
    assign next_flags[SUM_LIMIT]   = (|start_hi) | (|fault_lo);
    assign next_flags[SUM_CLASS]   = |disc_hi;
    assign next_flags[SUM_DETECT]  = |disc_lo;
    assign next_flags[SUM_UNPLUG]  = |fault_hi;
    assign next_flags[SUM_PGOOD]   = |power_hi;
    assign next_flags[SUM_PENABLE] = |power_lo;
    // flags follow events regardless of masks; only the pin is gated
    assign alert_req    = alert_global_enable && |(next_flags & alert_mask_i);               // RULE18 RULE20
    assign next_alert_n = !alert_req;                                                        // RULE4

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            alert_flags_o <= READ_ZERO;
            alert_n_o     <= 1'b1;
        end else begin
            alert_flags_o <= next_flags;
            alert_n_o     <= next_alert_n;
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    logic [7:0] power_view;
    logic [7:0] disc_view;
    logic [7:0] fault_view;
    logic [7:0] start_view;
    logic [7:0] supply_view;
    logic [7:0] next_rd_data;
    logic       unmapped_hit;

    // both codes of a pair return the value held before the clear lands
    assign power_view   = (sel == SEL_POWER)  ? power_if.value : READ_ZERO;
    assign disc_view    = (sel == SEL_DISC)   ? disc_if.value : READ_ZERO;
    assign fault_view   = (sel == SEL_FAULT)  ? fault_if.value : READ_ZERO;                  // RULE1
    assign start_view   = (sel == SEL_START)  ? start_if.value : READ_ZERO;                  // RULE2
    assign supply_view  = (sel == SEL_SUPPLY) ? supply_if.value & SUPPLY_USED_MASK : READ_ZERO; // RULE3
    // views are zero unless selected, so an or makes the mux
    assign next_rd_data = power_view | disc_view | fault_view | start_view | supply_view;
    assign unmapped_hit = cmd_valid_i && (sel == SEL_NONE);

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            rd_data_o     <= READ_ZERO;
            rd_valid_o    <= 1'b0;
            rd_unmapped_o <= 1'b0;
        end else begin
            rd_data_o     <= next_rd_data;
            rd_valid_o    <= cmd_valid_i;
            rd_unmapped_o <= unmapped_hit;
        end
    end
endmodule

// >>> verif/pse_host_model.sv
`timescale 1ns/1ps
// ----
// host side: one read command at a time
// ----
module pse_host_model (
    input  wire logic       mclk_i,
    input  wire logic [7:0] rd_data_i,
    input  wire logic       rd_valid_i,
    input  wire logic       rd_unmapped_i,
    output logic            cmd_valid_o,
    output logic      [7:0] cmd_code_o
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_code_o  = 8'h00;
    end
    // strobe one cycle, then take the answer at the edge it is seen
    task automatic read(input logic [7:0] code, output logic [7:0] data, output logic unm, output logic ok);
        @(posedge mclk_i);
        cmd_valid_o <= 1'b1;
        cmd_code_o  <= code;
        @(posedge mclk_i);
        cmd_valid_o <= 1'b0;
        ok = 1'b0;
        // bounded: a lost answer must not hang the run
        for (int n = 0; n < 4 && !ok; n++) begin
            @(posedge mclk_i);
            ok = rd_valid_i;
        end
        data = rd_data_i;
        unm  = rd_unmapped_i;
    endtask
endmodule

// >>> verif/pse_event_status_registers_assertions.sv
`timescale 1ns/1ps
module pse_event_checker
    import pse_event_pkg::*;
(
    input wire logic       mclk_i,
    input wire logic       nrst_i,
    input wire logic       cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [7:0] rd_data_o,
    input wire logic       rd_valid_o,
    input wire logic       rd_unmapped_o,
    input wire logic [3:0] unplug_i,
    input wire logic [3:0] overload_trip_i,
    input wire logic [7:0] supply_event_i,
    input wire logic [3:0] channel_off_i,
    input wire logic [7:0] alert_mask_i,
    input wire logic       alert_global_enable,
    input wire logic [7:0] alert_flags_o,
    input wire logic       alert_n_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);
    // ----
    // clearing read, gap of two cycles, plain read of same register
    // ----
    sequence s_pair(c, q, r);
        cmd_valid_i && cmd_code_i == c && q ##1 r [*2] ##1 cmd_valid_i && cmd_code_i == c - 8'h01;
    endsequence
    property p_answer;
        cmd_valid_i |=> rd_valid_o;
    endproperty
    a_answer: assert property (p_answer) else $error("command not answered");
    property p_unmapped;
        cmd_valid_i && (cmd_code_i < 8'h02 || cmd_code_i > 8'h0b) |=> rd_unmapped_o && rd_data_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped code not flagged");
    property p_fault_clr;
        s_pair(CMD_FAULT_EVENT_CLR, unplug_i == 4'h0 && overload_trip_i == 4'h0,
               unplug_i == 4'h0 && overload_trip_i == 4'h0) |=> rd_data_o == 8'h00;
    endproperty
    a_fault_clr: assert property (p_fault_clr) else $error("fault bits survive clear");
    property p_supply_clr;
        s_pair(CMD_SUPPLY_EVENT_CLR, supply_event_i == 8'h00, supply_event_i == 8'h00) |=> rd_data_o == 8'h00;
    endproperty
    a_supply_clr: assert property (p_supply_clr) else $error("supply bits survive clear");
    property p_keep;
        s_pair(CMD_FAULT_EVENT_CLR, unplug_i[0] && !channel_off_i[0], !channel_off_i[0]) |=> rd_data_o[4];
    endproperty
    a_keep: assert property (p_keep) else $error("event lost in clear cycle");
    property p_off;
        channel_off_i == 4'hf ##1 channel_off_i == 4'hf && cmd_valid_i && cmd_code_i == CMD_FAULT_EVENT
            |=> rd_data_o == 8'h00;
    endproperty
    a_off: assert property (p_off) else $error("fault bits kept while off");
    property p_summary;
        unplug_i[0] && !channel_off_i[0] |-> ##2 alert_flags_o[SUM_UNPLUG];
    endproperty
    a_summary: assert property (p_summary) else $error("summary flag missing");
    // alert follows flags once mask, enable and flags have held a cycle
    property p_alert;
        $stable(alert_flags_o) && $stable(alert_mask_i) && $stable(alert_global_enable)
            |-> alert_n_o == !(alert_global_enable && (alert_flags_o & alert_mask_i) != 8'h00);
    endproperty
    a_alert: assert property (p_alert) else $error("alert level wrong");
endmodule
bind pse_event_status_registers pse_event_checker pse_event_checker_i (
    .mclk_i, .nrst_i, .cmd_valid_i, .cmd_code_i, .rd_data_o, .rd_valid_o, .rd_unmapped_o, .unplug_i,
    .overload_trip_i, .supply_event_i, .channel_off_i, .alert_mask_i, .alert_global_enable, .alert_flags_o,
    .alert_n_o);

// >>> verif/tb_pse_event_status_registers.sv
`timescale 1ns/1ps
module tb_pse_event_status_registers
    import pse_event_pkg::*;
;
    logic       mclk_i, nrst_i, cmd_valid_i, class_change_only_sel, detect_change_only_sel;
    logic       auto_mode_i, alert_global_enable, rd_valid_o, rd_unmapped_o, alert_n_o, power_on_fault_upd_o;
    logic [7:0] cmd_code_i, rd_data_o, start_cause_i, supply_event_i, alert_mask_i, alert_flags_o, power_on_fault_o;
    logic [3:0] pgood_change_i, penable_change_i, class_done_i, class_differs_i, detect_done_i, detect_differs_i;
    logic [3:0] unplug_i, overload_trip_i, current_clamp_i, start_timer_fault_i, discovery_error_i;
    logic [3:0] channel_off_i, inrush_fault_o;
    logic [7:0] got;
    logic       unm;
    logic       ok;
    int         failures;
    int         tests_run;
    pse_event_status_registers pse_event_status_registers_i (.*);
    pse_host_model pse_host_model_i (.mclk_i, .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o),
        .rd_unmapped_i(rd_unmapped_o), .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i));
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end
    // ----
    // shared tasks
    // ----
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] code, input logic [7:0] exp);
        pse_host_model_i.read(code, got, unm, ok);
        if (ok !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: no answer", $time);
            end_sim();
        end
        check(got, exp);
    endtask
    // pulses end one edge after they start
    task automatic quiet;
        @(posedge mclk_i);
        {pgood_change_i, penable_change_i, class_done_i, class_differs_i, detect_done_i, detect_differs_i} <= '0;
        {unplug_i, overload_trip_i, current_clamp_i, start_timer_fault_i, discovery_error_i} <= '0;
        supply_event_i <= 8'h00;
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_reset;
        rd(CMD_FAULT_EVENT, 8'h00);
        rd(CMD_START_EVENT, 8'h00);
        rd(CMD_SUPPLY_EVENT, 8'h70);
        rd(8'h0c, 8'h00);
        check({7'h00, unm}, 8'h01);
        check(alert_flags_o, 8'h80);
        $display("test reset done");
    endtask
    task automatic t_fault;
        @(posedge mclk_i);
        alert_mask_i <= 8'h04;
        alert_global_enable <= 1'b1;
        unplug_i <= 4'h2;
        overload_trip_i <= 4'h8;
        quiet();
        repeat (3) @(posedge mclk_i);
        check({7'h00, alert_n_o}, 8'h00);
        check(alert_flags_o, 8'ha4);
        rd(CMD_FAULT_EVENT, 8'h28);
        rd(CMD_FAULT_EVENT_CLR, 8'h28);
        rd(CMD_FAULT_EVENT, 8'h00);
        repeat (3) @(posedge mclk_i);
        check({7'h00, alert_n_o}, 8'h01);
        $display("test fault done");
    endtask
    task automatic t_start;
        @(posedge mclk_i);
        auto_mode_i <= 1'b1;
        current_clamp_i <= 4'h1;
        start_timer_fault_i <= 4'h4;
        penable_change_i <= 4'h4;
        pgood_change_i <= 4'h8;
        start_cause_i <= 8'hff;
        discovery_error_i <= 4'h2;
        quiet();
        rd(CMD_START_EVENT, 8'h14);
        check({4'h0, inrush_fault_o}, 8'h04);
        check(power_on_fault_o, 8'h00);
        rd(CMD_START_EVENT_CLR, 8'h14);
        rd(CMD_START_EVENT, 8'h00);
        rd(CMD_POWER_EVENT_CLR, 8'h84);
        @(posedge mclk_i);
        auto_mode_i <= 1'b0;
        discovery_error_i <= 4'h2;
        start_cause_i <= 8'h04;
        quiet();
        @(posedge mclk_i);
        check({7'h00, power_on_fault_upd_o}, 8'h01);
        check(power_on_fault_o, 8'h04);
        rd(CMD_START_EVENT_CLR, 8'h02);
        $display("test start done");
    endtask
    task automatic t_supply;
        @(posedge mclk_i);
        supply_event_i <= 8'hff;
        quiet();
        rd(CMD_SUPPLY_EVENT_CLR, 8'hf3);
        rd(CMD_SUPPLY_EVENT, 8'h00);
        $display("test supply done");
    endtask
    task automatic t_disc;
        @(posedge mclk_i);
        class_change_only_sel <= 1'b1;
        class_done_i <= 4'h1;
        detect_done_i <= 4'h8;
        @(posedge mclk_i);
        class_done_i <= 4'h2;
        class_differs_i <= 4'h2;
        detect_done_i <= 4'h0;
        quiet();
        rd(CMD_DISC_EVENT_CLR, 8'h28);
        class_change_only_sel <= 1'b0;
        detect_change_only_sel <= 1'b1;
        class_done_i <= 4'h1;
        detect_done_i <= 4'h3;
        detect_differs_i <= 4'h2;
        quiet();
        rd(CMD_DISC_EVENT_CLR, 8'h12);
        $display("test discovery done");
    endtask
    task automatic t_off_keep;
        @(posedge mclk_i);
        unplug_i <= 4'h1;
        current_clamp_i <= 4'h1;
        quiet();
        channel_off_i <= 4'hf;
        rd(CMD_FAULT_EVENT, 8'h00);
        rd(CMD_START_EVENT, 8'h00);
        check({4'h0, inrush_fault_o}, 8'h00);
        channel_off_i <= 4'h0;
        fork
            pse_host_model_i.read(CMD_FAULT_EVENT_CLR, got, unm, ok);
            begin
                @(posedge mclk_i);
                unplug_i <= 4'h1;
                quiet();
            end
        join
        check({7'h00, ok}, 8'h01);
        check(got, 8'h00);
        rd(CMD_FAULT_EVENT, 8'h10);
        $display("test off and keep done");
    endtask
    initial begin
        failures = 0;
        tests_run = 0;
        nrst_i = 1'b0;
        {class_change_only_sel, detect_change_only_sel, auto_mode_i, alert_global_enable} = '0;
        {pgood_change_i, penable_change_i, class_done_i, class_differs_i, detect_done_i, detect_differs_i} = '0;
        {unplug_i, overload_trip_i, current_clamp_i, start_timer_fault_i, discovery_error_i} = '0;
        {start_cause_i, supply_event_i, alert_mask_i, channel_off_i} = '0;
        repeat (3) @(posedge mclk_i);
        nrst_i <= 1'b1;
        t_reset();
        t_fault();
        t_start();
        t_supply();
        t_disc();
        t_off_keep();
        end_sim();
    end
endmodule
